//--- etd_map.svh
// Purpose: Register map, field positions, reset values and timing constants of the 8-bit timer.
// Assumes: Included by the package and design modules; definitions only.
// Notes:   Offsets are byte addresses on the plain register port.
`ifndef ETD_MAP_SVH
`define ETD_MAP_SVH
`define ETD_ADDR_W          4
`define ETD_OFF_CTRL        4'h0
`define ETD_OFF_CMP         4'h4
`define ETD_OFF_STAT        4'h8
`define ETD_OFF_LCTRL       4'hc
`define ETD_CTRL_RST        8'h00
`define ETD_CMP_RST         8'hff
`define ETD_LCTRL_RST       8'h00
`define ETD_BIT_TFF         7
`define ETD_BIT_RUN         3
`define ETD_CK_HI           6
`define ETD_CK_LO           4
`define ETD_MODE_HI         2
`define ETD_MODE_LO         0
`define ETD_BIT_SLOW        7
`define ETD_BIT_DV          6
`define ETD_LCK_HI          2
`define ETD_LCK_LO          0
`define ETD_CK_PIN          3'h7
`define ETD_PRE_W           12
`define ETD_TAP_11          11
`define ETD_TAP_7           7
`define ETD_TAP_5           5
`define ETD_TAP_3           3
`define ETD_TAP_1           1
`define ETD_FS_DIV_DEF      1525
`define ETD_FS_TAP_3        3
`endif

//--- etd_pkg.sv
// Purpose: Shared types of the 8-bit timer.
// Assumes: Macros come from etd_map.svh.
// Notes:   Only codes 000 and 001 of the mode field are served here.
`include "etd_map.svh"
package etd_pkg;
    typedef enum logic [2:0] {
        ETD_MODE_TIMER = 3'h0,
        ETD_MODE_PDO   = 3'h1
    } etd_mode_e;
    typedef enum logic {
        ETD_STOPPED,
        ETD_RUNNING
    } etd_state_e;
endpackage

//--- etd_tick_gen.sv
// Purpose: Prescaler producing one-cycle tick enables for clock select codes 0 to 6 (only code 0 in slow mode); code 7 never ticks.
// Assumes: core_clk stands in for fc; fs is a divided enable.
// Notes:   Ticks of codes 0 to 3 and 5 are rising edges of divider bits, so each is a single-cycle pulse; code 6 ticks every cycle.
`timescale 1ns/1ps
`include "etd_map.svh"
module etd_tick_gen #(
    parameter int FS_DIV = `ETD_FS_DIV_DEF
) (
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic [2:0] sel,
    input  wire logic       slow_mode,
    input  wire logic       tap_select,
    output logic            tick
);
    logic [`ETD_PRE_W-1:0] pre_reg, pre_next;
    logic [15:0]           fsd_reg, fsd_next;
    logic [3:0]            fsp_reg, fsp_next;
    logic                  tick_reg, tick_next;
    logic                  fs_en;
    logic [`ETD_PRE_W-1:0] pre_rise;
    logic [3:0]            fsp_rise;

    assign tick = tick_reg;

    always_comb begin
        fs_en    = (fsd_reg == 16'(FS_DIV - 1));
        fsd_next = fs_en ? 16'h0000 : fsd_reg + 16'h0001;
        fsp_next = fs_en ? fsp_reg + 4'h1 : fsp_reg;
        pre_next = pre_reg + {{(`ETD_PRE_W-1){1'b0}}, 1'b1};
        pre_rise = pre_next & ~pre_reg;
        fsp_rise = fsp_next & ~fsp_reg;
        // In slow operation only the slowest tap is offered; other codes stall.
        // Bit n-1 of a divider rises once per 2^n cycles, so that is the tap for /2^n.
        if (slow_mode) begin
            tick_next = (sel == 3'h0) && fsp_rise[`ETD_FS_TAP_3 - 1];
        end else begin
            unique case (sel)
                3'h0: tick_next = tap_select ? fsp_rise[`ETD_FS_TAP_3 - 1] :
                                               pre_rise[`ETD_TAP_11 - 1];
                3'h1: tick_next = pre_rise[`ETD_TAP_7 - 1];
                3'h2: tick_next = pre_rise[`ETD_TAP_5 - 1];
                3'h3: tick_next = pre_rise[`ETD_TAP_3 - 1];
                3'h4: tick_next = fs_en;
                3'h5: tick_next = pre_rise[`ETD_TAP_1 - 1];
                3'h6: tick_next = 1'b1;
                3'h7: tick_next = 1'b0;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pre_reg  <= '0;
            fsd_reg  <= '0;
            fsp_reg  <= '0;
            tick_reg <= 1'b0;
        end else begin
            pre_reg  <= pre_next;
            fsd_reg  <= fsd_next;
            fsp_reg  <= fsp_next;
            tick_reg <= tick_next;
        end
    end
endmodule

//--- etd_timer.sv
// Purpose: 8-bit timer, event counter and programmable divider output.
// Assumes: Plain register port; event pin asynchronous to core_clk.
// Notes:   Cascaded, pulse width and pattern modes are not built.
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "etd_map.svh"
module etd_timer #(
    parameter int FS_DIV = `ETD_FS_DIV_DEF
) (
    input  wire logic                   core_clk,
    input  wire logic                   rstn,
    input  wire logic [`ETD_ADDR_W-1:0] addr,
    input  wire logic [7:0]             wdata,
    input  wire logic                   wr,
    input  wire logic                   rd,
    output logic      [7:0]             rdata,
    input  wire logic                   event_input_pin,
    output logic                        divider_output_pin_n,
    output logic                        match_interrupt
);
    logic [7:0] timer_control_reg, timer_control_next;
    logic [7:0] compare_value_reg, compare_value_next;
    logic [7:0] lower_control_reg, lower_control_next;
    logic [7:0] count_reg, count_next;
    logic       tff_reg, tff_next;
    logic       pdo_reg, pdo_next;
    logic       irq_reg, irq_next;
    logic       match_seen_reg, match_seen_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [2:0] ev_sync_reg;
    logic [2:0] ev_sync_next;
    etd_pkg::etd_state_e state_reg, state_next;
    logic       tick;
    logic       fall;
    logic       step;
    logic       hit;
    logic       run_control_bit;
    logic [2:0] clock_select_field;
    logic [2:0] mode_select_field;
    logic [2:0] sel_eff;

    assign run_control_bit    = timer_control_reg[`ETD_BIT_RUN];
    assign clock_select_field = timer_control_reg[`ETD_CK_HI:`ETD_CK_LO];
    assign mode_select_field  = timer_control_reg[`ETD_MODE_HI:`ETD_MODE_LO];
    // Cascade modes would take the lower-byte select; 8-bit modes use their own.
    assign sel_eff = mode_select_field[2] ?
                     lower_control_reg[`ETD_LCK_HI:`ETD_LCK_LO] : clock_select_field;

    etd_tick_gen #(
        .FS_DIV (FS_DIV)
    ) u_tick (
        .core_clk   (core_clk),
        .rstn       (rstn),
        .sel        (sel_eff),
        .slow_mode  (lower_control_reg[`ETD_BIT_SLOW]),
        .tap_select (lower_control_reg[`ETD_BIT_DV]),
        .tick       (tick)
    );

    // The pin is synchronised; its first stage feeds only the second.
    always_comb begin
        ev_sync_next = {ev_sync_reg[1:0], event_input_pin};
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ev_sync_reg <= 3'h7;
        end else begin
            ev_sync_reg <= ev_sync_next;
        end
    end

    // Edge detection relies on levels lasting two machine cycles.
    assign fall = ev_sync_reg[2] & ~ev_sync_reg[1];

    always_comb begin
        // Event counting is the pin source under mode 000.
        if (clock_select_field == `ETD_CK_PIN) begin
            step = (mode_select_field == etd_pkg::ETD_MODE_TIMER) && fall;
        end else begin
            step = tick;
        end
        // The live compare value is used with no shadow copy.
        hit = step && (count_reg + 8'h01 == compare_value_reg);
    end

    // Register port: writes take effect next cycle, reads answer one cycle later.
    always_comb begin
        timer_control_next = timer_control_reg;
        compare_value_next = compare_value_reg;
        lower_control_next = lower_control_reg;
        rdata_next         = 8'h00;
        if (wr) begin
            unique case (addr)
                `ETD_OFF_CTRL:  timer_control_next = wdata;
                `ETD_OFF_CMP:   compare_value_next = wdata;
                `ETD_OFF_LCTRL: lower_control_next = wdata;
                default:        ;
            endcase
        end
        if (rd) begin
            unique case (addr)
                `ETD_OFF_CTRL:  rdata_next = timer_control_reg;
                `ETD_OFF_CMP:   rdata_next = compare_value_reg;
                `ETD_OFF_STAT:  rdata_next = count_reg;
                `ETD_OFF_LCTRL: rdata_next = {match_seen_reg, tff_reg,
                                              lower_control_reg[5:0]};
                default:        rdata_next = 8'h00;
            endcase
        end
    end

    always_comb begin
        state_next      = run_control_bit ? etd_pkg::ETD_RUNNING : etd_pkg::ETD_STOPPED;
        count_next      = count_reg;
        tff_next        = tff_reg;
        irq_next        = 1'b0;
        match_seen_next = match_seen_reg;
        if (rd && addr == `ETD_OFF_LCTRL) begin
            match_seen_next = 1'b0;
        end
        unique case (state_reg)
            etd_pkg::ETD_STOPPED: begin
                // Hold while stopped; a control write loads the flip-flop.
                if (wr && addr == `ETD_OFF_CTRL) begin
                    tff_next = wdata[`ETD_BIT_TFF];
                end
                if (run_control_bit) begin
                    count_next = 8'h00;
                end
            end
            etd_pkg::ETD_RUNNING: begin
                if (!run_control_bit) begin
                    // The stop write has landed: count and pin hold, and only a later
                    // control write may load a new flip-flop level.
                    if (wr && addr == `ETD_OFF_CTRL) begin
                        tff_next = wdata[`ETD_BIT_TFF];
                    end
                end else if (hit) begin
                    count_next      = 8'h00;
                    irq_next        = 1'b1;
                    match_seen_next = 1'b1;
                    if (mode_select_field == etd_pkg::ETD_MODE_PDO) begin
                        tff_next = ~tff_reg;
                    end
                end else if (step) begin
                    count_next = count_reg + 8'h01;
                end
            end
        endcase
    end

    always_comb begin
        pdo_next = ~tff_next;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            timer_control_reg <= `ETD_CTRL_RST;
            compare_value_reg <= `ETD_CMP_RST;
            lower_control_reg <= `ETD_LCTRL_RST;
            count_reg         <= 8'h00;
            tff_reg           <= 1'b0;
            pdo_reg           <= 1'b1;
            irq_reg           <= 1'b0;
            match_seen_reg    <= 1'b0;
            rdata_reg         <= 8'h00;
            state_reg         <= etd_pkg::ETD_STOPPED;
        end else begin
            timer_control_reg <= timer_control_next;
            compare_value_reg <= compare_value_next;
            lower_control_reg <= lower_control_next;
            count_reg         <= count_next;
            tff_reg           <= tff_next;
            pdo_reg           <= pdo_next;
            irq_reg           <= irq_next;
            match_seen_reg    <= match_seen_next;
            rdata_reg         <= rdata_next;
            state_reg         <= state_next;
        end
    end

    assign rdata                = rdata_reg;
    assign divider_output_pin_n = pdo_reg;
    assign match_interrupt      = irq_reg;
endmodule

//--- etd_timer_props.sv
// Purpose: Port assertions for the 8-bit timer.
// Assumes: Control writes go to address 0 and compare writes to address 4.
// Notes:   Helper flops mirror the writes, since the checker sees ports only.
`timescale 1ns/1ps
`include "etd_map.svh"
module etd_timer_props #(
    parameter int FS_DIV = 4
) (
    input wire logic                   core_clk,
    input wire logic                   rstn,
    input wire logic [`ETD_ADDR_W-1:0] addr,
    input wire logic [7:0]             wdata,
    input wire logic                   wr,
    input wire logic                   rd,
    input wire logic [7:0]             rdata,
    input wire logic                   event_input_pin,
    input wire logic                   divider_output_pin_n,
    input wire logic                   match_interrupt
);
    logic       run_q;
    logic [2:0] ck_q;
    logic [7:0] cmp_q;
    logic [7:0] gap;
    logic       clean;
    logic       ev_q;
    logic [3:0] age;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            run_q <= 1'b0;
            ck_q  <= 3'h0;
            cmp_q <= 8'hff;
            gap   <= 8'h00;
            clean <= 1'b0;
            ev_q  <= 1'b1;
            age   <= 4'hf;
        end else begin
            if (wr && addr == 4'h0) begin
                run_q <= wdata[3];
                ck_q  <= wdata[6:4];
            end
            if (wr && addr == 4'h4) begin
                cmp_q <= wdata;
            end
            gap   <= match_interrupt ? 8'h01 : gap + 8'h01;
            clean <= match_interrupt | (clean & ~wr);
            ev_q  <= event_input_pin;
            age   <= (ev_q & ~event_input_pin) ? 4'h0 : (age == 4'hf) ? age : age + 4'h1;
        end
    end
    irq_pulse_a: assert property (@(posedge core_clk) disable iff (!rstn)
        match_interrupt |=> !match_interrupt) else $error("match pulse too long");
    period_cmp_a: assert property (@(posedge core_clk) disable iff (!rstn)
        match_interrupt && clean && ck_q == 3'h6 |-> gap == cmp_q)
        else $error("match period differs from compare value");
    cmp_readback_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (wr && addr == 4'h4) ##2 (rd && addr == 4'h4) |=> rdata == $past(wdata, 3))
        else $error("compare value not in effect");
    pin_reset_a: assert property (@(posedge core_clk) disable iff (!rstn)
        $rose(rstn) |-> divider_output_pin_n) else $error("output pin low after reset");
    stop_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
        !run_q && !$past(run_q) && !$past(run_q, 2) && !$past(wr)
        |-> $stable(divider_output_pin_n)) else $error("output pin moved while stopped");
    stop_quiet_a: assert property (@(posedge core_clk) disable iff (!rstn)
        match_interrupt |-> $past(run_q) || $past(run_q, 2)) else $error("match while stopped");
    toggle_cause_a: assert property (@(posedge core_clk) disable iff (!rstn)
        $changed(divider_output_pin_n) && !$past(wr)
        |-> ##[0:1] (match_interrupt || $past(match_interrupt)))
        else $error("output pin toggled without a match");
    event_cause_a: assert property (@(posedge core_clk) disable iff (!rstn)
        run_q && ck_q == 3'h7 && match_interrupt |-> age <= 4'h4)
        else $error("event match not after a falling edge");
endmodule
bind etd_timer etd_timer_props #(.FS_DIV(FS_DIV)) u_props (
    .core_clk(core_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .event_input_pin(event_input_pin),
    .divider_output_pin_n(divider_output_pin_n), .match_interrupt(match_interrupt));

//--- etd_event_src.sv
// Purpose: Event pulse source standing at the event pin.
// Assumes: hold is eight or more core cycles per level.
// Notes:   Idles high between bursts, so no stray edge is seen.
`timescale 1ns/1ps
module etd_event_src (
    input  wire logic       core_clk,
    input  wire logic       go,
    input  wire logic [3:0] hold,
    output logic            event_input_pin
);
    logic lvl  = 1'b1;
    int   left = 0;
    assign event_input_pin = lvl;
    always @(posedge core_clk) begin
        if (left > 1) begin
            left <= left - 1;
        end else if (go || !lvl) begin
            lvl  <= !lvl;
            left <= hold;
        end
    end
endmodule

//--- eight_bit_timer_event_divider_test.sv
// Purpose: Self-checking bench for the 8-bit timer.
// Assumes: FS_DIV is cut to 4 so the slow taps finish quickly.
// Notes:   Periods are taken between match pulses, so start latency cancels.
`timescale 1ns/1ps
module eight_bit_timer_event_divider_test;
    logic        core_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        go = 1'b0;
    logic [3:0]  hold = 4'h8;
    logic [7:0]  rdata, v, w;
    logic        ev_pin, pin_n, irq, prev, md;
    logic [31:0] seed = 32'h06c6c237;
    int          err_count = 0;
    int          compares = 0;
    int          n, m, falls, irqs;
    int          div_tab [9] = '{2048, 32, 32, 128, 32, 8, 4, 2, 1};
    logic [2:0]  ck_tab [9] = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
    logic [7:0]  aux_tab [9] = '{8'h00, 8'h40, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    always #10 core_clk = ~core_clk;
    etd_timer #(.FS_DIV(4)) dut (.core_clk(core_clk), .rstn(rstn), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .event_input_pin(ev_pin),
        .divider_output_pin_n(pin_n), .match_interrupt(irq));
    etd_event_src u_src (.core_clk(core_clk), .go(go), .hold(hold), .event_input_pin(ev_pin));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        @(negedge core_clk);
        d = rdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_irq(output int k);
        k = 0;
        do begin
            @(negedge core_clk);
            k++;
        end while (irq !== 1'b1 && k < 9000);
        if (irq !== 1'b1) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, irq, 1'b1);
        end
    endtask
    task automatic summarize();
        $display("compares %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge core_clk);
        err_count++;
        summarize();
    end
    initial begin
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        rd_reg(4'h0, v);
        chk(v, 8'h00);
        rd_reg(4'h4, v);
        chk(v, 8'hff);
        rd_reg(4'hc, v);
        chk(v, 8'h00);
        wr_reg(4'h8, 8'h55);
        rd_reg(4'h8, v);
        chk(v, 8'h00);
        rd_reg(4'h2, v);
        chk(v, 8'h00);
        chk(pin_n, 1'b1);
        $display("reset test done");
        for (int i = 0; i < 9; i++) begin
            m = (div_tab[i] > 1000) ? 2 : 2 + int'(rnd() % 5);
            md = i[0];
            wr_reg(4'h0, {1'b0, ck_tab[i], 1'b0, 2'b00, md});
            wr_reg(4'hc, aux_tab[i]);
            wr_reg(4'h4, m[7:0]);
            wr_reg(4'h0, {1'b0, ck_tab[i], 1'b1, 2'b00, md});
            wait_irq(n);
            @(negedge core_clk);
            chk(pin_n, !md);
            wait_irq(n);
            chk(n, m * div_tab[i] - 1);
            wr_reg(4'h0, {1'b0, ck_tab[i], 1'b0, 2'b00, md});
        end
        $display("tap test done");
        wr_reg(4'h4, 8'h03);
        rd_reg(4'h4, v);
        chk(v, 8'h03);
        wr_reg(4'h0, 8'h39);
        wait_irq(n);
        wr_reg(4'h0, 8'h31);
        repeat (20) @(negedge core_clk);
        chk(pin_n, 1'b0);
        rd_reg(4'h8, v);
        rd_reg(4'h8, w);
        chk(w, v);
        wr_reg(4'h0, 8'hb1);
        wr_reg(4'h0, 8'h31);
        @(negedge core_clk);
        chk(pin_n, 1'b1);
        wr_reg(4'h0, 8'hb1);
        rd_reg(4'hc, v);
        chk({v[6], pin_n}, 2'b10);
        $display("stop test done");
        @(posedge core_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        @(negedge core_clk);
        chk(pin_n, 1'b1);
        rd_reg(4'hc, v);
        chk(v, 8'h00);
        wr_reg(4'h4, 8'h03);
        $display("mid-run reset test done");
        wr_reg(4'h0, 8'h70);
        wr_reg(4'h0, 8'h78);
        prev = 1'b1;
        falls = 0;
        irqs = 0;
        for (int k = 0; k < 340; k++) begin
            @(negedge core_clk);
            go <= (k < 300);
            hold <= 4'(4'h8 + rnd() % 4);
            falls += (prev && !ev_pin) ? 1 : 0;
            irqs += (irq === 1'b1) ? 1 : 0;
            prev = ev_pin;
        end
        chk(irqs, falls / 3);
        rd_reg(4'h8, v);
        chk(v, falls % 3);
        $display("event test done");
        summarize();
    end
endmodule
